// File: tb/ltb_handler.sv
`timescale 1ns/1ps
// Device handler: takes a bin from lines 1..3 when line four rises
module ltb_handler (
   input  wire logic       i_clock,   // System clock
   input  wire logic       i_rstn,    // Async reset, active low
   input  wire logic [3:0] i_dig_out, // Lines from the block
   output logic      [2:0] o_bin,     // Last bin taken
   output logic      [7:0] o_n_eot    // End-of-test pulses seen
);
   logic l4_q;
   // Bin is read on the rising edge of line four
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         l4_q <= 1'b1; // Line four rests high after reset
         o_bin <= 3'h0;
         o_n_eot <= 8'h00;
      end else begin
         l4_q <= i_dig_out[3];
         if (i_dig_out[3] && !l4_q) begin
            o_bin <= i_dig_out[2:0];
            o_n_eot <= o_n_eot + 8'h01;
         end
      end
   end
endmodule

// File: tb/tb_limit_test_digital_binning.sv
`timescale 1ns/1ps
module tb_limit_test_digital_binning;
   import ltb_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rstn = 1'b0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic        compl_ch1 = 1'b0;
   logic        compl_ch2 = 1'b0;
   logic [3:0]  dig_out;
   logic        busy;
   logic [2:0]  bin;
   logic [7:0]  n_eot;
   logic [31:0] rd;
   int          mismatches = 0;
   int          n_tests = 0;
   int          cycles = 0;

   ltb_top #(.AC_MAX_CYC(1000)) ltb_top_i (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_avs_address(address), .i_avs_read(read),
      .i_avs_write(write), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_compl_ch1(compl_ch1),
      .i_compl_ch2(compl_ch2), .o_dig_out(dig_out), .o_busy(busy));
   ltb_handler ltb_handler_i (.i_clock(i_clock), .i_rstn(i_rstn), .i_dig_out(dig_out), .o_bin(bin),
      .o_n_eot(n_eot));

   // Clock and hang guard
   always #5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // One bus access, held until waitrequest is sampled low
   task automatic acc(input logic is_wr, input logic [7:0] off, input logic [31:0] d);
      @(posedge i_clock);
      address <= off[7:2];
      write <= is_wr;
      read <= !is_wr;
      wdata <= d;
      @(posedge i_clock);
      while (waitreq !== 1'b0) @(posedge i_clock);
      rd = rdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      acc(1'b1, off, d);
   endtask

   task automatic rchk(input logic [7:0] off, input logic [31:0] exp, input string what);
      acc(1'b0, off, 32'h0);
      chk(what, exp, rd);
   endtask

   task automatic pchk(input logic [3:0] exp);
      repeat (2) @(posedge i_clock);
      chk("port", {28'h0, exp}, {28'h0, dig_out});
   endtask

   function automatic logic [31:0] cw(input logic [5:0] en, input logic [1:0] hf, input logic [1:0] fd,
                                      input logic [5:0] fl);
      return {16'h0, fl, fd, hf, en};
   endfunction

   task automatic sw(input logic [7:0] i, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] pat);
      logic [7:0] b;
      b = LTB_OFF_SW_BASE + LTB_SW_STRIDE * i;
      wr(b + LTB_SW_LO, lo);
      wr(b + LTB_SW_HI, hi);
      wr(b + LTB_SW_PAT, pat);
   endtask

   // Start one reading and wait for the evaluation pulse
   task automatic ev(input logic last);
      int i;
      wr(LTB_OFF_ACTION, 32'h1 | ({31'h0, last} << LTB_A_LAST));
      for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge i_clock);
      chk("busy", 32'h1, {31'h0, busy});
      repeat (3) @(posedge i_clock);
   endtask

   // Clear results, evaluate one reading, judge port and flags
   task automatic cs(input logic [31:0] ctrl, input logic c1, input logic c2, input logic [31:0] v,
                     input logic [3:0] ep, input logic [5:0] ef);
      wr(LTB_OFF_CTRL, ctrl);
      wr(LTB_OFF_ACTION, 32'h1 << LTB_A_CLRRES);
      compl_ch1 <= c1;
      compl_ch2 <= c2;
      wr(LTB_OFF_CH1, v);
      ev(1'b1);
      pchk(ep);
      acc(1'b0, LTB_OFF_STATUS, 32'h0);
      chk("flags", {26'h0, ef}, {26'h0, rd[5:0]});
   endtask

   task automatic t_grade();
      logic [31:0] g;
      g = cw(6'h0C, 2'h0, LTB_FEED_CH1, 6'h04);
      sw(8'h0, 32'd4, 32'd10, 32'h0004_0502);
      sw(8'h1, 32'd6, 32'd8, 32'h0007_0603);
      wr(LTB_OFF_PASSPAT, 32'h0000_0E01);
      cs(g, 1'b0, 1'b0, 32'd7, 4'h1, 6'h00);
      cs(g, 1'b0, 1'b0, 32'd5, 4'h3, 6'h08);
      cs(g, 1'b0, 1'b0, 32'd11, 4'h5, 6'h0C);
      cs(g, 1'b0, 1'b0, 32'd4, 4'h3, 6'h08);
      cs(g, 1'b0, 1'b0, 32'd10, 4'h6, 6'h08);
   endtask

   task automatic t_hw();
      wr(LTB_OFF_HWPAT, 32'h0000_0C09);
      cs(cw(6'h03, 2'h1, LTB_FEED_CH1, 6'h04), 1'b0, 1'b1, 32'd7, 4'h1, 6'h00);
      cs(cw(6'h03, 2'h1, LTB_FEED_CH1, 6'h04), 1'b1, 1'b1, 32'd7, 4'h9, 6'h01);
      cs(cw(6'h03, 2'h1, LTB_FEED_CH1, 6'h04), 1'b0, 1'b0, 32'd7, 4'hC, 6'h02);
      cs(cw(6'h02, 2'h1, LTB_FEED_CH1, 6'h04), 1'b1, 1'b1, 32'd7, 4'h1, 6'h00);
   endtask

   task automatic t_sort();
      logic [31:0] s;
      s = cw(6'h0C, 2'h0, LTB_FEED_CH1, 6'h05);
      cs(s, 1'b0, 1'b0, 32'd7, 4'h4, 6'h00);
      cs(s, 1'b0, 1'b0, 32'd9, 4'h4, 6'h08);
      cs(s, 1'b0, 1'b0, 32'd12, 4'hE, 6'h0C);
      cs(cw(6'h08, 2'h0, LTB_FEED_CH1, 6'h05), 1'b0, 1'b0, 32'd7, 4'h7, 6'h00);
      cs(cw(6'h0D, 2'h1, LTB_FEED_CH1, 6'h05), 1'b1, 1'b0, 32'd7, 4'h9, 6'h01);
   endtask

   task automatic t_feed();
      logic [3:0] ep [4] = '{4'h2, 4'h1, 4'h5, 4'h2};
      wr(LTB_OFF_CH2, 32'd7);
      wr(LTB_OFF_RATIO, 32'd20);
      wr(LTB_OFF_DELTA, 32'hFFFF_FFFD);
      for (int k = 0; k < 4; k++) begin
         cs(cw(6'h04, 2'h0, 2'(k), 6'h04), 1'b0, 1'b0, 32'd1, ep[k], (ep[k] == 4'h1) ? 6'h00 : 6'h04);
      end
   endtask

   task automatic t_bins();
      wr(LTB_OFF_CTRL, cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h06));
      wr(LTB_OFF_ACTION, 32'h1 << LTB_A_CLRRES);
      wr(LTB_OFF_CH1, 32'd12);
      ev(1'b0);
      pchk(4'h0);
      wr(LTB_OFF_CH1, 32'd7);
      ev(1'b1);
      pchk(4'h5);
      wr(LTB_OFF_CTRL, cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h04));
      wr(LTB_OFF_ACTION, 32'h1 << LTB_A_CLRRES);
      wr(LTB_OFF_CH1, 32'd12);
      ev(1'b0);
      pchk(4'h5);
   endtask

   task automatic t_clear();
      wr(LTB_OFF_PASSPAT, 32'h0003_0E01);
      cs(cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h04), 1'b0, 1'b0, 32'd12, 4'h5, 6'h04);
      wr(LTB_OFF_ACTION, 32'h1 << LTB_A_CLROUT);
      pchk(4'h3);
      rchk(LTB_OFF_CTRL, cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h04), "ctrl kept");
      wr(LTB_OFF_PORT_SET, 32'hA);
      pchk(4'hA);
      rchk(LTB_OFF_PORT_RD, 32'hA, "port readback");
      wr(LTB_OFF_ACTION, 32'h1 << LTB_A_CLRRES);
      pchk(4'h3);
      rchk(LTB_OFF_STATUS, 32'h0, "status cleared");
      rchk(8'h30, 32'h0, "unmapped read");
   endtask

   task automatic t_line4();
      logic [7:0] n0;
      repeat (LTB_EOT_CYC) @(posedge i_clock);
      n0 = n_eot;
      cs(cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h10), 1'b0, 1'b0, 32'd12, 4'hD, 6'h04);
      chk("handler bin", 32'h5, {29'h0, bin});
      chk("eot count", {24'h0, n0 + 8'h01}, {24'h0, n_eot});
      repeat (LTB_EOT_CYC) @(posedge i_clock);
      pchk(4'h5);
      wr(LTB_OFF_CTRL, cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h08));
      pchk(4'hD);
      ev(1'b1);
      pchk(4'hD);
   endtask

   task automatic t_auto();
      wr(LTB_OFF_ACDLY, 32'd2);
      cs(cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h24), 1'b0, 1'b0, 32'd12, 4'h5, 6'h04);
      repeat (150) @(posedge i_clock);
      pchk(4'h5);
      repeat (100) @(posedge i_clock);
      pchk(4'h3);
      wr(LTB_OFF_ACDLY, 32'd100);
      cs(cw(6'h04, 2'h0, LTB_FEED_CH1, 6'h24), 1'b0, 1'b0, 32'd12, 4'h5, 6'h04);
      repeat (1100) @(posedge i_clock);
      pchk(4'h3);
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge i_clock);
      i_rstn <= 1'b1;
      pchk(4'h8);
      rchk(LTB_OFF_CTRL, LTB_CTRL_RST, "ctrl reset");
      t_grade();
      t_hw();
      t_sort();
      t_feed();
      t_bins();
      t_clear();
      t_line4();
      t_auto();
      give_verdict();
   end
endmodule

// File: verilog/ltb_pkg.sv
package ltb_pkg;
   // Register byte offsets
   localparam logic [7:0] LTB_OFF_CTRL     = 8'h00;
   localparam logic [7:0] LTB_OFF_ACTION   = 8'h04;
   localparam logic [7:0] LTB_OFF_STATUS   = 8'h08;
   localparam logic [7:0] LTB_OFF_PORT_SET = 8'h0C;
   localparam logic [7:0] LTB_OFF_PORT_RD  = 8'h10;
   localparam logic [7:0] LTB_OFF_PASSPAT  = 8'h14;
   localparam logic [7:0] LTB_OFF_HWPAT    = 8'h18;
   localparam logic [7:0] LTB_OFF_ACDLY    = 8'h1C;
   localparam logic [7:0] LTB_OFF_CH1      = 8'h20;
   localparam logic [7:0] LTB_OFF_CH2      = 8'h24;
   localparam logic [7:0] LTB_OFF_RATIO    = 8'h28;
   localparam logic [7:0] LTB_OFF_DELTA    = 8'h2C;
   localparam logic [7:0] LTB_OFF_SW_BASE  = 8'h40;
   localparam logic [7:0] LTB_SW_STRIDE    = 8'h10;
   localparam logic [7:0] LTB_SW_LO        = 8'h00;
   localparam logic [7:0] LTB_SW_HI        = 8'h04;
   localparam logic [7:0] LTB_SW_PAT       = 8'h08;
   // CTRL field positions
   localparam int LTB_C_EN      = 0;
   localparam int LTB_C_HWFAIL  = 6;
   localparam int LTB_C_FEED    = 8;
   localparam int LTB_C_MODE    = 10;
   localparam int LTB_C_BCON    = 11;
   localparam int LTB_C_WIDTH4  = 12;
   localparam int LTB_C_L4BUSY  = 13;
   localparam int LTB_C_L4POL   = 14;
   localparam int LTB_C_ACEN    = 15;
   // ACTION bits
   localparam int LTB_A_START   = 0;
   localparam int LTB_A_CLRRES  = 1;
   localparam int LTB_A_CLROUT  = 2;
   localparam int LTB_A_LAST    = 3;
   // Reset values
   localparam logic [31:0] LTB_CTRL_RST = 32'h0000_0000;
   localparam logic [3:0]  LTB_PAT_RST  = 4'h0;
   // Timing
   localparam int LTB_CLK_MHZ          = 100;
   localparam int LTB_EOT_PULSE_NS     = 1000;
   localparam int LTB_EOT_CYC          = LTB_EOT_PULSE_NS * LTB_CLK_MHZ / 1000;
   localparam longint LTB_AC_MAX_S     = 60;
   localparam longint LTB_AC_MAX_CYC   = LTB_AC_MAX_S * LTB_CLK_MHZ * 1000000;
   localparam int LTB_US_CYC           = LTB_CLK_MHZ;
   typedef enum logic [1:0] {LTB_FEED_CH1, LTB_FEED_CH2, LTB_FEED_RATIO, LTB_FEED_DELTA} ltb_feed_e;
endpackage

// File: verilog/ltb_top.sv
`timescale 1ns/1ps
// What this block does
// - Each hardware limit fails on compliance (IN) or on non-compliance (OUT), selectable.
// - Hardware limit one watches channel 1, limit two watches channel 2.
// - Each hardware limit owns a fail pattern driven on failure.
// - All six tests have enables; disabled tests never judge.
// - A readable result flag per test: 0 pass, 1 fail.
// - Software limits share one feed: ch1, ch2, ratio or delta.
// - Each software limit holds its own lower and upper bound.
// - Grading uses separate low and high fail patterns per software limit.
// - Sorting uses a pass pattern per software limit band.
// - One composite pass pattern marks overall pass.
// - One composite sorting fail pattern when no enabled band fits.
// - Bin control: update at first failure, or only at sweep end.
// - Clear-results wipes flags and clears the port.
// - Mode selects grading or sorting mapping.
// - Port width is 3 or 4 bits.
// - Software may write the port directly.
// - Current port value is readable.
// - Line four is end-of-test, busy or port data.
// - Line four active polarity is selectable.
// - Output-clear drives the clear pattern, config untouched.
// - Auto-clear with delay holds result then clears.
// - Grading outputs first failing compliance, high or low pattern, else pass.
// - Sorting fails on compliance or no band; first passing band wins.
// - Auto-clear width 0 to 60 s, then programmable clear pattern.
// - Unless busy is selected, 3-bit end-of-test pulses line four; 4-bit uses line four as data.
module ltb_top #(
   parameter int unsigned DW           = 32,            // Reading width
   parameter longint      AC_MAX_CYC   = ltb_pkg::LTB_AC_MAX_CYC // Auto-clear ceiling, cycles
) (
   input  wire logic                i_clock,           // 100 MHz clock
   input  wire logic                i_rstn,            // Async reset, active low
   input  wire logic [5:0]          i_avs_address,     // Word address
   input  wire logic                i_avs_read,        // Read request
   input  wire logic                i_avs_write,       // Write request
   input  wire logic [31:0]         i_avs_writedata,   // Write data
   input  wire logic [3:0]          i_avs_byteenable,  // Byte lanes
   output logic      [31:0]         o_avs_readdata,    // Read data
   output logic                     o_avs_waitrequest, // Stall
   input  wire logic                i_compl_ch1,       // Channel 1 in compliance
   input  wire logic                i_compl_ch2,       // Channel 2 in compliance
   output logic      [3:0]          o_dig_out,         // Digital output lines 1..4
   output logic                     o_busy             // Evaluation in progress
);
   import ltb_pkg::*;

   // Refuse parameter values the logic cannot serve
   if (DW < 2 || DW > 32) begin : g_bad_dw
      $error("DW out of range");
   end
   if (AC_MAX_CYC < 1) begin : g_bad_ac
      $error("AC_MAX_CYC must be positive");
   end

   typedef enum logic [1:0] {LTB_IDLE, LTB_EVAL, LTB_SHOW} ltb_state_e;

   logic [31:0]            ctrl_q;
   logic [3:0]             pass_pat_q, sfail_pat_q, clr_pat_q;
   logic [3:0]             hw_pat_q [2];
   logic [31:0]            ac_dly_us_q;
   logic signed [DW-1:0]   feed_val_q [4];
   logic signed [DW-1:0]   lo_q [4];
   logic signed [DW-1:0]   hi_q [4];
   logic [3:0]             lo_pat_q [4];
   logic [3:0]             hi_pat_q [4];
   logic [3:0]             band_pat_q [4];
   logic [5:0]             result_q;
   logic [3:0]             port_q;
   logic [3:0]             pend_pat_q;
   logic                   pend_fail_q;
   logic                   last_q;
   logic                   eot_q;
   logic [15:0]            eot_cnt_q;
   logic [63:0]            ac_cnt_q;
   logic                   ac_run_q;
   logic                   wait_q;
   ltb_state_e             state_q;

   // Bus decode
   logic        wr, rd;
   logic [7:0]  badr;
   logic        act_start, act_clrres, act_clrout;
   assign wr   = i_avs_write && !o_avs_waitrequest;
   assign rd   = i_avs_read && o_avs_waitrequest;   // Read answered from the wait cycle
   assign badr = {i_avs_address, 2'b00};
   assign act_start  = wr && badr == LTB_OFF_ACTION && i_avs_writedata[LTB_A_START];
   assign act_clrres = wr && badr == LTB_OFF_ACTION && i_avs_writedata[LTB_A_CLRRES];
   assign act_clrout = wr && badr == LTB_OFF_ACTION && i_avs_writedata[LTB_A_CLROUT];

   // Field views
   logic        mode_sort, bcon_end, width4, l4_busy, l4_pol, ac_en;
   logic [5:0]  en;
   logic [1:0]  hw_fail_in;
   ltb_feed_e   feed;
   assign en         = ctrl_q[LTB_C_EN +: 6];
   assign hw_fail_in = ctrl_q[LTB_C_HWFAIL +: 2];
   assign feed       = ltb_feed_e'(ctrl_q[LTB_C_FEED +: 2]);
   assign mode_sort  = ctrl_q[LTB_C_MODE];
   assign bcon_end   = ctrl_q[LTB_C_BCON];
   assign width4     = ctrl_q[LTB_C_WIDTH4];
   assign l4_busy    = ctrl_q[LTB_C_L4BUSY];
   assign l4_pol     = ctrl_q[LTB_C_L4POL];
   assign ac_en      = ctrl_q[LTB_C_ACEN];

   // Wait state: every access answers one cycle after request
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) wait_q <= 1'b1;
      else if ((i_avs_read || i_avs_write) && wait_q) wait_q <= 1'b0;
      else wait_q <= 1'b1;
   end
   assign o_avs_waitrequest = wait_q;

   // Byte-enabled merge
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) if (be[b]) r[b*8 +: 8] = n[b*8 +: 8];
      return r;
   endfunction

   // Configuration registers
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q      <= LTB_CTRL_RST;
         pass_pat_q  <= LTB_PAT_RST;
         sfail_pat_q <= LTB_PAT_RST;
         clr_pat_q   <= LTB_PAT_RST;
         hw_pat_q[0] <= LTB_PAT_RST;
         hw_pat_q[1] <= LTB_PAT_RST;
         ac_dly_us_q <= 32'h0000_0000;
         last_q      <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            feed_val_q[i] <= '0;
            lo_q[i] <= '0;
            hi_q[i] <= '0;
            lo_pat_q[i] <= LTB_PAT_RST;
            hi_pat_q[i] <= LTB_PAT_RST;
            band_pat_q[i] <= LTB_PAT_RST;
         end
      end else if (wr) begin
         case (badr)
            LTB_OFF_CTRL:    ctrl_q <= merge(ctrl_q, i_avs_writedata, i_avs_byteenable);
            LTB_OFF_ACTION:  last_q <= i_avs_writedata[LTB_A_LAST];
            LTB_OFF_PASSPAT: begin
               pass_pat_q  <= i_avs_writedata[3:0];
               sfail_pat_q <= i_avs_writedata[11:8];
               clr_pat_q   <= i_avs_writedata[19:16];
            end
            LTB_OFF_HWPAT: begin
               hw_pat_q[0] <= i_avs_writedata[3:0];
               hw_pat_q[1] <= i_avs_writedata[11:8];
            end
            LTB_OFF_ACDLY:   ac_dly_us_q <= i_avs_writedata;
            LTB_OFF_CH1:     feed_val_q[0] <= i_avs_writedata[DW-1:0];
            LTB_OFF_CH2:     feed_val_q[1] <= i_avs_writedata[DW-1:0];
            LTB_OFF_RATIO:   feed_val_q[2] <= i_avs_writedata[DW-1:0];
            LTB_OFF_DELTA:   feed_val_q[3] <= i_avs_writedata[DW-1:0];
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (badr == LTB_OFF_SW_BASE + 8'(i) * LTB_SW_STRIDE + LTB_SW_LO) begin
                     lo_q[i] <= i_avs_writedata[DW-1:0];
                  end
                  if (badr == LTB_OFF_SW_BASE + 8'(i) * LTB_SW_STRIDE + LTB_SW_HI) hi_q[i] <= i_avs_writedata[DW-1:0];
                  if (badr == LTB_OFF_SW_BASE + 8'(i) * LTB_SW_STRIDE + LTB_SW_PAT) begin
                     lo_pat_q[i]   <= i_avs_writedata[3:0];
                     hi_pat_q[i]   <= i_avs_writedata[11:8];
                     band_pat_q[i] <= i_avs_writedata[19:16];
                  end
               end
            end
         endcase
      end
   end

   // Evaluation of one reading
   logic signed [DW-1:0] sel_val;
   logic [1:0]  hw_fail;
   logic [3:0]  lo_fail, hi_fail;
   logic [5:0]  fail_vec;
   logic [3:0]  eval_pat;
   logic        eval_fail;
   always_comb begin
      sel_val   = feed_val_q[feed];
      hw_fail[0] = en[0] && (hw_fail_in[0] ? i_compl_ch1 : !i_compl_ch1);
      hw_fail[1] = en[1] && (hw_fail_in[1] ? i_compl_ch2 : !i_compl_ch2);
      for (int i = 0; i < 4; i++) begin
         lo_fail[i] = en[2+i] && (sel_val < lo_q[i]);
         hi_fail[i] = en[2+i] && !lo_fail[i] && (sel_val > hi_q[i]);
      end
      fail_vec  = {lo_fail | hi_fail, hw_fail};
      eval_pat  = pass_pat_q;
      eval_fail = 1'b0;
      if (hw_fail[0]) begin
         eval_pat = hw_pat_q[0];
         eval_fail = 1'b1;
      end else if (hw_fail[1]) begin
         eval_pat = hw_pat_q[1];
         eval_fail = 1'b1;
      end else if (!mode_sort) begin
         for (int i = 3; i >= 0; i--) begin
            if (hi_fail[i]) begin
               eval_pat = hi_pat_q[i];
               eval_fail = 1'b1;
            end else if (lo_fail[i]) begin
               eval_pat = lo_pat_q[i];
               eval_fail = 1'b1;
            end
         end
      end else if (en[5:2] != 4'h0) begin
         eval_pat = sfail_pat_q;
         eval_fail = 1'b1;
         for (int i = 3; i >= 0; i--) begin
            if (en[2+i] && !lo_fail[i] && !hi_fail[i]) begin
               eval_pat = band_pat_q[i];
               eval_fail = 1'b0;
            end
         end
      end
   end

   // Sequencer and result flags
   logic start_ok;
   assign start_ok = act_start && state_q != LTB_EVAL;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q     <= LTB_IDLE;
         result_q    <= 6'h00;
         pend_pat_q  <= LTB_PAT_RST;
         pend_fail_q <= 1'b0;
      end else if (act_clrres) begin
         state_q     <= LTB_IDLE;
         result_q    <= 6'h00;
         pend_fail_q <= 1'b0;
      end else begin
         case (state_q)
            LTB_IDLE, LTB_SHOW: if (start_ok) state_q <= LTB_EVAL;
            LTB_EVAL: begin
               result_q <= fail_vec;
               if (!pend_fail_q) pend_pat_q <= eval_pat;
               pend_fail_q <= pend_fail_q | eval_fail;
               state_q <= LTB_SHOW;
            end
            default: state_q <= LTB_IDLE;
         endcase
         if (state_q == LTB_SHOW && start_ok && last_q == 1'b0 && !bcon_end) pend_fail_q <= 1'b0;
      end
   end

   // Port update decision
   logic show_now, sweep_done;
   assign sweep_done = state_q == LTB_EVAL && (last_q || (!bcon_end && (eval_fail || !mode_sort)));
   assign show_now   = state_q == LTB_EVAL && (!bcon_end ? (eval_fail || last_q) : last_q);
   logic [3:0] show_pat;
   assign show_pat = pend_fail_q ? pend_pat_q : eval_pat;

   // Digital output value
   logic ac_done;
   assign ac_done = ac_run_q && ac_cnt_q == 64'h0;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) port_q <= LTB_PAT_RST;
      else if (act_clrres || act_clrout || ac_done) port_q <= clr_pat_q;
      else if (wr && badr == LTB_OFF_PORT_SET) port_q <= i_avs_writedata[3:0];
      else if (show_now) port_q <= show_pat;
   end

   // Auto-clear hold timer in clock cycles
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ac_run_q <= 1'b0;
         ac_cnt_q <= 64'h0;
      end else if (show_now && ac_en) begin
         ac_run_q <= 1'b1;
         ac_cnt_q <= (64'(ac_dly_us_q) * 64'(LTB_US_CYC) > 64'(AC_MAX_CYC)) ?
                     64'(AC_MAX_CYC) : 64'(ac_dly_us_q) * 64'(LTB_US_CYC);
      end else if (ac_done || act_clrout || act_clrres || !ac_en) begin
         ac_run_q <= 1'b0;
      end else if (ac_run_q) begin
         ac_cnt_q <= ac_cnt_q - 64'h1;
      end
   end

   // End-of-test pulse
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         eot_q     <= 1'b0;
         eot_cnt_q <= 16'h0000;
      end else if (sweep_done) begin
         eot_q     <= 1'b1;
         eot_cnt_q <= 16'(LTB_EOT_CYC - 1);
      end else if (eot_cnt_q != 16'h0000) begin
         eot_cnt_q <= eot_cnt_q - 16'h0001;
      end else begin
         eot_q <= 1'b0;
      end
   end

   // Registered pins; line four per width and function
   logic busy_now;
   assign busy_now = state_q == LTB_EVAL;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dig_out <= {~LTB_CTRL_RST[LTB_C_L4POL], 3'h0}; // Line four rests inactive
         o_busy    <= 1'b0;
      end else begin
         o_busy       <= busy_now;
         o_dig_out[2:0] <= port_q[2:0];
         if (l4_busy) o_dig_out[3] <= busy_now ^ !l4_pol;
         else if (width4) o_dig_out[3] <= port_q[3];
         else o_dig_out[3] <= eot_q ^ !l4_pol;
      end
   end

   // Read mux, loaded in the wait state so data stands when waitrequest drops
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) o_avs_readdata <= 32'h0000_0000;
      else if (rd) begin
         case (badr)
            LTB_OFF_CTRL:    o_avs_readdata <= ctrl_q;
            LTB_OFF_STATUS:  o_avs_readdata <= {24'h0, pend_fail_q, busy_now, result_q};
            LTB_OFF_PORT_SET,
            LTB_OFF_PORT_RD: o_avs_readdata <= {28'h0, o_dig_out};
            LTB_OFF_PASSPAT: o_avs_readdata <= {12'h0, clr_pat_q, 4'h0, sfail_pat_q, 4'h0, pass_pat_q};
            LTB_OFF_HWPAT:   o_avs_readdata <= {20'h0, hw_pat_q[1], 4'h0, hw_pat_q[0]};
            LTB_OFF_ACDLY:   o_avs_readdata <= ac_dly_us_q;
            default:         o_avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Assertions
   AST_CLR_RES: assert property (@(posedge i_clock) disable iff (!i_rstn)
      act_clrres |=> result_q == 6'h00) else $error("results not cleared");
   AST_CLR_OUT: assert property (@(posedge i_clock) disable iff (!i_rstn)
      act_clrout |=> port_q == $past(clr_pat_q)) else $error("port not cleared");
   AST_DIS: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_q == LTB_EVAL && !act_clrres) |=> (result_q & ~$past(en)) == 6'h00) else $error("disabled test flagged");
   AST_HW1: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_q == LTB_EVAL && en[0] && !act_clrres && (hw_fail_in[0] == i_compl_ch1)) |=> result_q[0])
      else $error("hw limit one missed");
   AST_WIN: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (en[2] && sel_val >= lo_q[0] && sel_val <= hi_q[0]) |-> !fail_vec[2]) else $error("window wrong");
   AST_SET: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (wr && badr == LTB_OFF_PORT_SET && !act_clrres && !ac_done)
      |=> ##1 o_dig_out[2:0] == $past(i_avs_writedata[2:0], 2))
      else $error("port write lost");
   AST_W4: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (width4 && !l4_busy) |=> o_dig_out[3] == $past(port_q[3])) else $error("line four not data");
   AST_BUSY: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (l4_busy && busy_now) |=> o_dig_out[3] == $past(l4_pol)) else $error("busy not shown");
   AST_ORDER: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (show_now && !act_clrres) |=> result_q == $past(fail_vec)) else $error("flags not updated with port");
   // Port not claimed by a clear or a direct write this cycle
   logic port_free;
   assign port_free = !act_clrres && !act_clrout && !ac_done && !(wr && badr == LTB_OFF_PORT_SET);
   AST_END: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_q == LTB_EVAL && bcon_end && !last_q && port_free) |=> port_q == $past(port_q))
      else $error("port updated before sweep end");
   AST_PASS: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (show_now && !mode_sort && !eval_fail && !pend_fail_q && port_free) |=> port_q == $past(pass_pat_q))
      else $error("pass pattern not shown");
   AST_SFAIL: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (show_now && mode_sort && eval_fail && hw_fail == 2'b00 && !pend_fail_q && port_free)
      |=> port_q == $past(sfail_pat_q)) else $error("sorting fail pattern not shown");
   AST_AC_MAX: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (show_now && ac_en) |=> ac_run_q && ac_cnt_q <= 64'(AC_MAX_CYC)) else $error("auto-clear hold too long");
   COV_GRADE_FAIL: cover property (@(posedge i_clock) show_now && eval_fail && !mode_sort);
   COV_END_SWEEP:  cover property (@(posedge i_clock) show_now && bcon_end);
   COV_SORT_BAND:  cover property (@(posedge i_clock) show_now && !eval_fail && mode_sort);
   COV_AUTOCLR:    cover property (@(posedge i_clock) ac_done);
endmodule
